// *** design/pulse_window_integrator.sv ***
/*
 * Pulse window integrator: trigger gate with hysteresis, window extension,
 * height, width and area measurement, overlap abort, laser delay alignment
 * and an AXI4-Lite register slave with a masked interrupt.
 * Assumes one detector sample per channel on every core_clk edge, produced
 * in the core_clk domain, and an AXI4-Lite master on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pwi_map.svh"
module pulse_window_integrator #(
    parameter int NCH = 2,
    parameter int SW = 16,
    parameter int AREAW = 32,
    parameter int AW = 10,
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [NCH-1:0][SW-1:0] sample,
    output logic event_valid,
    output logic [NCH-1:0][AREAW-1:0] event_area,
    output logic [NCH-1:0][SW-1:0] event_height,
    output logic [15:0] event_width,
    output logic abort_pulse,
    output logic irq,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int DEPTH = 2 ** AW;
    localparam int LW = NCH * 8;
    localparam int HALF_CYC = `PWI_HALF_UNIT_CYC;

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic gate;
        pwi_pkg::win_state_t st;
        logic [AW-1:0] cnt;
        logic abort;
        logic [NCH-1:0][AREAW-1:0] area;
        logic [NCH-1:0][SW-1:0] hgt;
        logic [15:0] wid;
        logic [15:0] gw;
        logic ev_v;
        logic ab_p;
        logic [NCH-1:0][AREAW-1:0] ev_area;
        logic [NCH-1:0][SW-1:0] ev_hgt;
        logic [15:0] ev_wid;
        logic [15:0] ev_gw;
        logic [3:0] we;
        logic [NCH-1:0] sel;
        logic [SW-1:0] thr;
        logic [NCH-1:0][7:0] ldly;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [31:0] evcnt;
        logic [31:0] abcnt;
        logic aw_v;
        logic [ADDR_W-1:0] aw_a;
        logic w_v;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic bv;
        logic [1:0] bresp;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rresp;
    } state_t;

    localparam state_t RST_VAL = '{
        st: pwi_pkg::S_IDLE,
        we: `PWI_WE_RESET,
        thr: SW'(`PWI_THR_RESET),
        sel: NCH'(1),
        default: '0
    };

    state_t q;
    state_t n;

    // history depth
    // Depth must exceed the largest laser delay plus half the largest extension.
    logic [NCH-1:0][SW-1:0] hmem [DEPTH];
    logic gmem [DEPTH];

    logic [AW-1:0] dext;
    logic [NCH-1:0][SW-1:0] x_al;
    logic [NCH-1:0][SW-1:0] xd;
    logic [NCH-1:0] above;
    logic [NCH-1:0] below;
    logic [SW-1:0] thr_lo;
    logic g_live;
    logic rise;
    logic dg;

    // half extension
    // Half the extension, in cycles, is both the pre and the post span.
    assign dext = AW'(q.we) * AW'(HALF_CYC);

    assign thr_lo = q.thr - (q.thr >> 2);

    // laser delay alignment
    // Zero delays bypass the buffer, which has not yet stored this cycle.
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            if (q.ldly[c] == 8'h00) begin
                x_al[c] = sample[c];
            end else begin
                x_al[c] = hmem[q.wptr - AW'(q.ldly[c])][c];
            end
            if ((AW'(q.ldly[c]) + dext) == '0) begin
                xd[c] = sample[c];
            end else begin
                xd[c] = hmem[q.wptr - AW'(q.ldly[c]) - dext][c];
            end
            above[c] = x_al[c] > q.thr;
            below[c] = x_al[c] <= thr_lo;
        end
    end

    // channel combination
    // Open on any selected channel; close only when all selected have fallen.
    assign g_live = q.gate ? |(~below & q.sel) : |(above & q.sel);
    assign rise = g_live & ~q.gate;
    assign dg = (dext == '0) ? g_live : gmem[q.wptr - dext];

    // continuous storage
    // The buffer is written every cycle, pulse or not.
    always_ff @(posedge core_clk) begin
        hmem[q.wptr] <= sample;
        gmem[q.wptr] <= g_live;
    end

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign s_axi_awready = ~q.aw_v & ~q.bv;
    assign s_axi_wready = ~q.w_v & ~q.bv;
    assign s_axi_arready = ~q.rv;

    // Next state: bus slave first, so hardware sets below win over clears.
    always_comb begin
        logic [31:0] wv;
        logic acc;
        logic fin;
        pwi_pkg::win_state_t ph;
        wv = '0;
        acc = 1'b0;
        fin = 1'b0;
        ph = (q.st == pwi_pkg::S_IDLE) ? pwi_pkg::S_PRE : q.st;
        n = q;
        n.wptr = q.wptr + 1'b1;
        n.gate = g_live;
        n.ev_v = 1'b0;
        n.ab_p = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_v = 1'b1;
            n.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_v = 1'b1;
            n.w_d = s_axi_wdata;
            n.w_s = s_axi_wstrb;
        end
        if (q.bv && s_axi_bready) begin
            n.bv = 1'b0;
        end
        // Write once both halves are held; counters are read only.
        if (q.aw_v && q.w_v) begin
            n.aw_v = 1'b0;
            n.w_v = 1'b0;
            n.bv = 1'b1;
            n.bresp = `PWI_RESP_OKAY;
            case ({q.aw_a[ADDR_W-1:2], 2'b00})
                `PWI_CTRL: begin
                    wv = wmerge(32'({q.sel, 4'h0, q.we}), q.w_d, q.w_s);
                    n.we = wv[`PWI_CTRL_WE_LSB +: 4];
                    n.sel = wv[`PWI_CTRL_SEL_LSB +: NCH];
                end
                `PWI_THRESH: begin
                    wv = wmerge(32'(q.thr), q.w_d, q.w_s);
                    n.thr = wv[SW-1:0];
                end
                `PWI_LDLY: begin
                    wv = wmerge(32'(q.ldly), q.w_d, q.w_s);
                    n.ldly = wv[LW-1:0];
                end
                `PWI_STATUS: begin
                    wv = wmerge(32'h0000_0000, q.w_d, q.w_s);
                    n.stat = q.stat & ~wv[1:0];
                end
                `PWI_MASK: begin
                    wv = wmerge(32'(q.mask), q.w_d, q.w_s);
                    n.mask = wv[1:0];
                end
                `PWI_EVCNT, `PWI_ABCNT, `PWI_STATE: begin
                    n.bresp = `PWI_RESP_OKAY;
                end
                default: begin
                    n.bresp = `PWI_RESP_SLVERR;
                end
            endcase
        end
        if (q.rv && s_axi_rready) begin
            n.rv = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            n.rv = 1'b1;
            n.rresp = `PWI_RESP_OKAY;
            case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
                `PWI_CTRL: n.rd = 32'({q.sel, 4'h0, q.we});
                `PWI_THRESH: n.rd = 32'(q.thr);
                `PWI_LDLY: n.rd = 32'(q.ldly);
                `PWI_STATUS: n.rd = 32'(q.stat);
                `PWI_MASK: n.rd = 32'(q.mask);
                `PWI_EVCNT: n.rd = q.evcnt;
                `PWI_ABCNT: n.rd = q.abcnt;
                `PWI_STATE: n.rd = 32'({q.st, q.gate});
                default: begin
                    n.rd = 32'h0000_0000;
                    n.rresp = `PWI_RESP_SLVERR;
                end
            endcase
        end
        // idle ignores samples
        // Accumulators restart only when a window begins.
        if (q.st == pwi_pkg::S_IDLE) begin
            n.area = '0;
            n.hgt = '0;
            n.wid = '0;
            n.gw = '0;
            n.cnt = '0;
            n.abort = 1'b0;
        end
        if (q.st != pwi_pkg::S_IDLE || rise) begin
            // overlap marks abort
            // A new gate inside a live window spoils both pulses.
            if (q.st != pwi_pkg::S_IDLE && rise) begin
                n.abort = 1'b1;
            end
            case (ph)
                pwi_pkg::S_PRE, pwi_pkg::S_GATE: begin
                    acc = 1'b1;
                    if (dg) begin
                        n.st = pwi_pkg::S_GATE;
                    end else if (ph == pwi_pkg::S_GATE) begin
                        if (dext == '0) begin
                            acc = 1'b0;
                            fin = 1'b1;
                        end else begin
                            n.cnt = AW'(1);
                            fin = (dext == AW'(1));
                            n.st = pwi_pkg::S_POST;
                        end
                    end else begin
                        n.st = pwi_pkg::S_PRE;
                    end
                end
                pwi_pkg::S_POST: begin
                    acc = 1'b1;
                    if (dg) begin
                        n.st = pwi_pkg::S_GATE;
                    end else begin
                        n.cnt = q.cnt + 1'b1;
                        fin = ((q.cnt + 1'b1) == dext);
                    end
                end
                default: begin
                    n.st = pwi_pkg::S_IDLE;
                end
            endcase
            if (acc) begin
                for (int c = 0; c < NCH; c++) begin
                    n.area[c] = n.area[c] + AREAW'(xd[c]);
                    if (xd[c] > n.hgt[c]) begin
                        n.hgt[c] = xd[c];
                    end
                end
                n.wid = n.wid + 1'b1;
                if (dg) begin
                    n.gw = n.gw + 1'b1;
                end
            end
            // A gate that opens as the window closes merges into it.
            if (fin && rise) begin
                n.st = pwi_pkg::S_PRE;
            end else if (fin) begin
                n.st = pwi_pkg::S_IDLE;
                if (n.abort) begin
                    n.abcnt = q.abcnt + 1'b1;
                    n.ab_p = 1'b1;
                    n.stat[`PWI_ST_ABORT] = 1'b1;
                end else begin
                    n.ev_v = 1'b1;
                    n.ev_area = n.area;
                    n.ev_hgt = n.hgt;
                    n.ev_wid = n.wid;
                    n.ev_gw = n.gw;
                    n.evcnt = q.evcnt + 1'b1;
                    n.stat[`PWI_ST_EVENT] = 1'b1;
                end
            end
        end
    end

    // Single state register; synchronous reset.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= RST_VAL;
        end else begin
            q <= n;
        end
    end

    assign event_valid = q.ev_v;
    assign event_area = q.ev_area;
    assign event_height = q.ev_hgt;
    assign event_width = q.ev_wid;
    assign abort_pulse = q.ab_p;
    assign irq = |(q.stat & q.mask);
    assign s_axi_bvalid = q.bv;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rv;
    assign s_axi_rdata = q.rd;
    assign s_axi_rresp = q.rresp;

    property p_cont;
        @(posedge core_clk) disable iff (rst)
        !$past(rst) |-> q.wptr == AW'($past(q.wptr) + 1'b1);
    endproperty
    a_cont: assert property (p_cont)
        else $error("history pointer stalled");

    property p_open;
        @(posedge core_clk) disable iff (rst)
        (rise && q.st == pwi_pkg::S_IDLE) |=> q.st != pwi_pkg::S_IDLE;
    endproperty
    a_open: assert property (p_open)
        else $error("window did not open on gate");

    property p_noev;
        @(posedge core_clk) disable iff (rst)
        q.ev_v |-> $past(q.st) != pwi_pkg::S_IDLE;
    endproperty
    a_noev: assert property (p_noev)
        else $error("event without a window");

    property p_close;
        @(posedge core_clk) disable iff (rst)
        (q.gate && !(|(~below & q.sel))) |=> !q.gate;
    endproperty
    a_close: assert property (p_close)
        else $error("gate held below close level");

    property p_seven;
        @(posedge core_clk) disable iff (rst)
        (q.we == 4'h7) |-> dext == 10'h15E;
    endproperty
    a_seven: assert property (p_seven)
        else $error("extension seven not 350 cycles");

    property p_span;
        @(posedge core_clk) disable iff (rst)
        (q.ev_v && $stable(q.we)) |-> q.ev_wid == 16'(q.ev_gw + 16'(dext) + 16'(dext));
    endproperty
    a_span: assert property (p_span)
        else $error("span differs from gate plus extension");

    property p_we0;
        @(posedge core_clk) disable iff (rst)
        (q.ev_v && q.we == 4'h0 && $past(q.we) == 4'h0) |-> q.ev_wid == q.ev_gw;
    endproperty
    a_we0: assert property (p_we0)
        else $error("width differs from gate with zero extension");

    property p_peak;
        @(posedge core_clk) disable iff (rst)
        q.ev_v |-> q.ev_area[0] >= AREAW'(q.ev_hgt[0]);
    endproperty
    a_peak: assert property (p_peak)
        else $error("area below peak");

    property p_abort;
        @(posedge core_clk) disable iff (rst)
        q.ab_p |-> !q.ev_v && q.abcnt == 32'($past(q.abcnt) + 1'b1);
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort not counted or event leaked");

    property p_src;
        @(posedge core_clk) disable iff (rst)
        rise |-> |(above & q.sel);
    endproperty
    a_src: assert property (p_src)
        else $error("gate opened on unselected channel");

    property p_evcnt;
        @(posedge core_clk) disable iff (rst)
        q.ev_v |-> q.evcnt == 32'($past(q.evcnt) + 1'b1) ##1 !q.ev_v;
    endproperty
    a_evcnt: assert property (p_evcnt)
        else $error("event count or pulse wrong");
endmodule
`default_nettype wire

// *** design/pwi_map.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * pulse window integrator. Assumes a 32-bit register bus with byte addresses.
 */
`ifndef PWI_MAP_SVH
`define PWI_MAP_SVH

// Register byte offsets.
`define PWI_CTRL 8'h00
`define PWI_THRESH 8'h04
`define PWI_LDLY 8'h08
`define PWI_STATUS 8'h0C
`define PWI_MASK 8'h10
`define PWI_EVCNT 8'h14
`define PWI_ABCNT 8'h18
`define PWI_STATE 8'h1C

// Field positions.
`define PWI_CTRL_WE_LSB 0
`define PWI_CTRL_SEL_LSB 8
`define PWI_ST_EVENT 0
`define PWI_ST_ABORT 1

// Reset values.
`define PWI_WE_RESET 4'h7
`define PWI_THR_RESET 16'h0100

// One extension step adds this much time on each side of the gate.
`define PWI_HALF_UNIT_NS 500
`define PWI_CLK_NS 10
`define PWI_HALF_UNIT_CYC (`PWI_HALF_UNIT_NS / `PWI_CLK_NS)

// Bus answers.
`define PWI_RESP_OKAY 2'h0
`define PWI_RESP_SLVERR 2'h2

`endif

// *** design/pwi_pkg.sv ***
/*
 * Types shared by the pulse window integrator.
 * Assumes nothing of its surroundings.
 */
package pwi_pkg;

    // Phase of the integration window.
    typedef enum logic [1:0] {
        S_IDLE,
        S_PRE,
        S_GATE,
        S_POST
    } win_state_t;

endpackage

// *** verif/adc_stream_model.sv ***
/*
 * Behavioural model of the detector converter that feeds the integrator.
 * Assumes the bench loads a short script per channel and then pulses go;
 * outside the script every channel shows the baseline level.
 */
`timescale 1ns/100ps
`default_nettype none
module adc_stream_model #(
    parameter int NCH = 2,
    parameter int SW = 16,
    parameter int LEN = 64
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [SW-1:0] base,
    output logic [NCH-1:0][SW-1:0] sample
);
    logic [SW-1:0] wave [NCH][LEN];
    int pos = LEN;

    // Fills every channel's script with one level.
    task automatic clear(input logic [SW-1:0] v);
        for (int c = 0; c < NCH; c++) begin
            for (int i = 0; i < LEN; i++) wave[c][i] = v;
        end
    endtask

    // Writes a flat stretch of n samples into one channel's script.
    task automatic put(input int c, input int from, input int n, input logic [SW-1:0] v);
        for (int i = from; i < from + n && i < LEN; i++) wave[c][i] = v;
    endtask

    // A converter never pauses, so a new value goes out on every edge.
    always @(posedge core_clk) begin
        if (rst) begin
            sample <= '0;
            pos <= LEN;
        end else if (go) begin
            for (int c = 0; c < NCH; c++) sample[c] <= wave[c][0];
            pos <= 1;
        end else begin
            for (int c = 0; c < NCH; c++) sample[c] <= (pos < LEN) ? wave[c][pos] : base;
            if (pos < LEN) pos <= pos + 1;
        end
    end
endmodule
`default_nettype wire

// *** verif/pulse_window_integrator_tb_top.sv ***
/*
 * Self-checking bench of the pulse window integrator: registers, gate,
 * window extension, aborts, laser delay and interrupt.
 * Assumes the design, its map header and the converter model compile first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pwi_map.svh"
module pulse_window_integrator_tb_top;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic [15:0] base = 16'h0000;
    logic [1:0][15:0] sample;
    logic event_valid;
    logic [1:0][31:0] event_area;
    logic [1:0][15:0] event_height;
    logic [15:0] event_width;
    logic abort_pulse;
    logic irq;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    int n_fail = 0;
    int n_compared = 0;
    int n_ev = 0;
    int n_ab = 0;
    logic [31:0] area0;
    logic [31:0] area1;
    logic [15:0] h0;
    logic [15:0] wid;
    logic [7:0] ra [6] = '{`PWI_THRESH, `PWI_LDLY, `PWI_STATUS, `PWI_MASK, `PWI_EVCNT, `PWI_ABCNT};
    logic [31:0] rv [6] = '{32'h0000_0100, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                            32'h0000_0000, 32'h0000_0000};
    int d;
    // Byte lanes offered with the next write.
    logic [3:0] strb = 4'hF;

    pulse_window_integrator dut_u (.core_clk, .rst, .sample, .event_valid, .event_area,
        .event_height, .event_width, .abort_pulse, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    adc_stream_model adc_u (.core_clk, .rst, .go, .base, .sample);

    // A 100 MHz clock.
    initial forever #5 core_clk = ~core_clk;

    // Results are latched mid-cycle, clear of the edge that updates them.
    always @(negedge core_clk) begin
        if (event_valid === 1'b1) begin
            n_ev++;
            wid = event_width;
            area0 = event_area[0];
            area1 = event_area[1];
            h0 = event_height[0];
        end
        if (abort_pulse === 1'b1) n_ab++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Handshakes are judged mid-cycle and acted on just after the edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic aw;
        logic w;
        logic b;
        logic [1:0] r;
        b = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // Only the watchdog may end this wait; the slave's latency is not assumed.
        while (!b) begin
            @(negedge core_clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
        check(32'(r), 32'(er));
        // One edge passes so the next call never re-raises bready in this time step.
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
        logic ar;
        logic rh;
        logic [31:0] v;
        logic [1:0] r;
        rh = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rh) begin
            @(negedge core_clk);
            ar = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid && s_axi_rready;
            v = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (rh) s_axi_rready <= 1'b0;
        end
        check(v, ev);
        check(32'(r), 32'(er));
        @(posedge core_clk);
    endtask

    // Plays the loaded script and waits, bounded, for the expected outcome.
    task automatic play(input int ev, input int ab, input int lim);
        int e0;
        int a0;
        e0 = n_ev;
        a0 = n_ab;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        for (int i = 0; i < lim && !(ev + ab > 0 && n_ev - e0 >= ev && n_ab - a0 >= ab); i++)
            @(posedge core_clk);
        repeat (8) @(posedge core_clk);
        check(32'(n_ev - e0), 32'(ev));
        check(32'(n_ab - a0), 32'(ab));
    endtask

    // A hang is cut short well beyond the expected run of some 4300 cycles.
    initial begin
        #300_000;
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(`PWI_CTRL, 32'h0000_0107, `PWI_RESP_OKAY);
        foreach (ra[i]) rd(ra[i], rv[i], `PWI_RESP_OKAY);
        rd(8'h20, 32'h0000_0000, `PWI_RESP_SLVERR);
        wr(8'h20, 32'h0000_0001, `PWI_RESP_SLVERR);
        wr(`PWI_EVCNT, 32'h0000_0005, `PWI_RESP_OKAY);
        // Only the low lane is enabled, so the upper threshold byte must survive.
        strb = 4'h1;
        wr(`PWI_THRESH, 32'h0000_FF55, `PWI_RESP_OKAY);
        strb = 4'hF;
        rd(`PWI_THRESH, 32'h0000_0155, `PWI_RESP_OKAY);
        wr(`PWI_THRESH, 32'h0000_0100, `PWI_RESP_OKAY);
        rd(`PWI_THRESH, 32'h0000_0100, `PWI_RESP_OKAY);
        // The history buffer is not reset, so let it fill with clean zeros.
        repeat (1100) @(posedge core_clk);
        wr(`PWI_CTRL, 32'h0000_0100, `PWI_RESP_OKAY);
        adc_u.clear(16'h0000);
        adc_u.put(0, 0, 5, 16'h0100);
        play(0, 0, 200);
        adc_u.put(0, 0, 3, 16'h0200);
        adc_u.put(0, 3, 4, 16'h00C1);
        play(1, 0, 200);
        check(32'(wid), 32'h0000_0007);
        check(area0, 32'h0000_0904);
        check(32'(h0), 32'h0000_0200);
        check(32'(irq), 32'h0000_0000);
        rd(`PWI_STATUS, 32'h0000_0001, `PWI_RESP_OKAY);
        wr(`PWI_MASK, 32'h0000_0001, `PWI_RESP_OKAY);
        check(32'(irq), 32'h0000_0001);
        wr(`PWI_STATUS, 32'h0000_0001, `PWI_RESP_OKAY);
        check(32'(irq), 32'h0000_0000);
        adc_u.clear(16'h0000);
        adc_u.put(0, 0, 4, 16'h0200);
        adc_u.put(0, 6, 4, 16'h0200);
        play(2, 0, 200);
        check(32'(wid), 32'h0000_0004);
        wr(`PWI_CTRL, 32'h0000_0200, `PWI_RESP_OKAY);
        adc_u.clear(16'h0000);
        adc_u.put(0, 0, 4, 16'h0200);
        adc_u.put(1, 20, 4, 16'h0200);
        play(1, 0, 200);
        check(area0, 32'h0000_0000);
        check(area1, 32'h0000_0800);
        wr(`PWI_LDLY, 32'h0000_0500, `PWI_RESP_OKAY);
        wr(`PWI_CTRL, 32'h0000_0300, `PWI_RESP_OKAY);
        adc_u.clear(16'h0000);
        adc_u.put(1, 0, 4, 16'h0200);
        adc_u.put(0, 5, 4, 16'h0200);
        play(1, 0, 200);
        check(32'(wid), 32'h0000_0004);
        check(area0 + area1, 32'h0000_1000);
        wr(`PWI_LDLY, 32'h0000_0000, `PWI_RESP_OKAY);
        // A flat baseline of one makes every extension sample add one to the area.
        base <= 16'h0001;
        adc_u.clear(16'h0001);
        adc_u.put(0, 0, 4, 16'h0200);
        foreach (ra[k]) if (k < 2) begin
            d = (k == 0 ? 1 : 7) * `PWI_HALF_UNIT_CYC;
            wr(`PWI_CTRL, 32'h0000_0100 | (k == 0 ? 1 : 7), `PWI_RESP_OKAY);
            repeat (800) @(posedge core_clk);
            play(1, 0, 4 * d + 200);
            check(32'(wid), 32'(4 + 2 * d));
            check(area0, 32'(2048 + 2 * d));
            check(32'(h0), 32'h0000_0200);
        end
        base <= 16'h0000;
        wr(`PWI_CTRL, 32'h0000_0101, `PWI_RESP_OKAY);
        wr(`PWI_MASK, 32'h0000_0002, `PWI_RESP_OKAY);
        adc_u.clear(16'h0000);
        adc_u.put(0, 0, 4, 16'h0200);
        adc_u.put(0, 20, 4, 16'h0200);
        repeat (200) @(posedge core_clk);
        play(0, 1, 400);
        check(32'(irq), 32'h0000_0001);
        rd(`PWI_ABCNT, 32'h0000_0001, `PWI_RESP_OKAY);
        rd(`PWI_STATUS, 32'h0000_0003, `PWI_RESP_OKAY);
        wr(`PWI_STATUS, 32'h0000_0003, `PWI_RESP_OKAY);
        check(32'(irq), 32'h0000_0000);
        rd(`PWI_EVCNT, 32'h0000_0007, `PWI_RESP_OKAY);
        stop_test();
    end
endmodule
`default_nettype wire
